/* File: hdl/oneshot_timer_params.svh */
// Register map, field positions and reset values of the one-shot / pulse measurement timer.
// Assumes a 32-bit APB data path with one aligned word for each register.
`ifndef ONESHOT_TIMER_PARAMS_SVH
`define ONESHOT_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_MODE 4'h0
`define REG_CTRL 4'h4
`define REG_TIMER 4'h8
`define REG_STATUS 4'hc

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_SEL_LO 0
`define MODE_SEL_HI 1
`define MODE_WIDTH_BIT 2
`define MODE_EDGE_BIT 3
`define MODE_PIN_LO 4
`define MODE_PIN_HI 5
`define MODE_TRIG_SRC_BIT 6
`define MODE_CLK_LO 7
`define MODE_CLK_HI 8
`define MODE_RESET 9'h000

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define CTRL_START_BIT 0
`define CTRL_ONESHOT_BIT 1
`define CTRL_GPIO_OUT_BIT 2
`define CTRL_GPIO_OE_BIT 3
`define STAT_RUN_BIT 0
`define STAT_OVF_BIT 1
`define STAT_VALID_BIT 2

// ----------------------------------------------------------------
// Prescaler terminal counts and edge count
// ----------------------------------------------------------------
`define PRESC_DIV8_MASK 5'h07
`define PRESC_DIV32 5'h1f
`define EDGES_VALID 2'h2

`endif

/* File: hdl/oneshot_timer_pkg.sv */
// Types shared by the one-shot / pulse measurement timer.
// Assumes nothing of its surroundings.
package oneshot_timer_pkg;

	typedef enum logic [1:0] {
		mode_timer_type_v,
		mode_event_type_v,
		mode_oneshot,
		mode_measure
	} mode_type;

	typedef enum logic [1:0] {
		clk_div1,
		clk_div8,
		clk_div32,
		clk_sub_div32
	} clk_sel_type;

	typedef enum logic [1:0] {
		pin_gpio,
		pin_trigger,
		pin_pulse,
		pin_unused
	} pin_fn_type;

endpackage

/* File: hdl/oneshot_and_pulse_measure_timer.sv */
// 16-bit timer channel with one-shot and pulse period/width measurement modes behind an APB slave.
// Assumes APB on ref_clk_i; the channel pin and the sub-clock arrive asynchronously, ovf_in_i is synchronous.
`timescale 1ns/1ps
`include "oneshot_timer_params.svh"

module oneshot_and_pulse_measure_timer #(
	parameter int W = 16,
	parameter int AW = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pin_in_i,
	input wire logic ovf_in_i,
	input wire logic subclk_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic pin_out_o,
	output logic pin_oe_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic rise(input logic cur, input logic prev);
		rise = cur & ~prev;
	endfunction

	function automatic logic tick_sel(input logic [1:0] sel, input logic [4:0] p, input logic sub_tick);
		unique case (oneshot_timer_pkg::clk_sel_type'(sel))
			oneshot_timer_pkg::clk_div1: tick_sel = 1'b1;
			oneshot_timer_pkg::clk_div8: tick_sel = (p & `PRESC_DIV8_MASK) == `PRESC_DIV8_MASK;
			oneshot_timer_pkg::clk_div32: tick_sel = p == `PRESC_DIV32;
			oneshot_timer_pkg::clk_sub_div32: tick_sel = sub_tick;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [8:0] mode_reg;
	logic start_flag;
	logic gpio_out;
	logic gpio_oe;
	logic [W-1:0] reload;
	logic [W-1:0] counter;
	logic running;
	logic ovf_flag;
	logic first_seen;
	logic [1:0] edges_seen;
	logic [4:0] presc;
	logic [4:0] sub_presc;
	logic pin_s1, pin_s2, pin_s3;
	logic sub_s1, sub_s2, sub_s3;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire oneshot_timer_pkg::mode_type mode = oneshot_timer_pkg::mode_type'(mode_reg[`MODE_SEL_HI:`MODE_SEL_LO]);
	wire oneshot_timer_pkg::pin_fn_type pin_fn =
		oneshot_timer_pkg::pin_fn_type'(mode_reg[`MODE_PIN_HI:`MODE_PIN_LO]);
	wire is_oneshot = mode == oneshot_timer_pkg::mode_oneshot;
	wire is_meas = mode == oneshot_timer_pkg::mode_measure;
	wire acc = ce_i & psel_i & penable_i & pready_o;
	wire wr = acc & pwrite_i;
	wire wr_mode = wr & (paddr_i == AW'(`REG_MODE));
	wire wr_ctrl = wr & (paddr_i == AW'(`REG_CTRL));
	wire wr_timer = wr & (paddr_i == AW'(`REG_TIMER));
	wire mapped = paddr_i == AW'(`REG_MODE) || paddr_i == AW'(`REG_CTRL) ||
		paddr_i == AW'(`REG_TIMER) || paddr_i == AW'(`REG_STATUS);
	wire next_start = wr_ctrl ? pwdata_i[`CTRL_START_BIT] : start_flag;
	wire start_rise = wr_ctrl & pwdata_i[`CTRL_START_BIT] & ~start_flag;

	// The sub-clock is divided on its synchronised edges, so it must run well below ref_clk_i / 2.
	wire sub_edge = rise(sub_s2, sub_s3);
	wire sub_tick = sub_edge & (sub_presc == `PRESC_DIV32);
	wire tick = ce_i & tick_sel(mode_reg[`MODE_CLK_HI:`MODE_CLK_LO], presc, sub_tick);

	wire pin_rise = rise(pin_s2, pin_s3);
	wire pin_fall = rise(pin_s3, pin_s2);
	wire sel_edge = mode_reg[`MODE_EDGE_BIT] ? pin_rise : pin_fall;
	wire meas_edge = ce_i & is_meas & start_flag &
		(mode_reg[`MODE_WIDTH_BIT] ? (pin_rise | pin_fall) : sel_edge);

	wire ext_trig = mode_reg[`MODE_TRIG_SRC_BIT] ? ovf_in_i : (pin_fn == oneshot_timer_pkg::pin_trigger) & sel_edge;
	wire sw_trig = wr_ctrl & pwdata_i[`CTRL_ONESHOT_BIT];
	wire trig = ce_i & is_oneshot & next_start & ((start_flag & ext_trig) | sw_trig);
	wire os_zero = is_oneshot & running & tick & (counter <= W'(1));
	wire meas_ovf = is_meas & start_flag & tick & (&counter) & ~meas_edge;
	wire next_irq = os_zero | (meas_edge & first_seen) | meas_ovf;

	// ----------------------------------------------------------------
	// Synchronisers and prescalers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{pin_s1, pin_s2, pin_s3} <= 3'h0;
			{sub_s1, sub_s2, sub_s3} <= 3'h0;
			presc <= 5'h00;
			sub_presc <= 5'h00;
		end else if (ce_i) begin
			{pin_s1, pin_s2, pin_s3} <= {pin_in_i, pin_s1, pin_s2};
			{sub_s1, sub_s2, sub_s3} <= {subclk_i, sub_s1, sub_s2};
			presc <= presc + 5'h01;
			if (sub_edge) begin
				sub_presc <= sub_presc + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg <= `MODE_RESET;
			{gpio_oe, gpio_out, start_flag} <= 3'h0;
		end else begin
			if (wr_mode) begin
				mode_reg <= pwdata_i[`MODE_CLK_HI:0];
			end
			if (wr_ctrl) begin
				start_flag <= pwdata_i[`CTRL_START_BIT];
				gpio_out <= pwdata_i[`CTRL_GPIO_OUT_BIT];
				gpio_oe <= pwdata_i[`CTRL_GPIO_OE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Counter and reload
	// ----------------------------------------------------------------
	// A trigger outranks the zero reload, so a retrigger on the last tick restarts the count.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			counter <= '0;
			reload <= '0;
		end else if (ce_i) begin
			if (is_meas) begin
				if (start_rise) begin
					counter <= '0;
				end else if (meas_edge) begin
					reload <= counter;
					counter <= '0;
				end else if (start_flag & tick) begin
					counter <= counter + W'(1);
				end
			end else begin
				if (wr_timer) begin
					reload <= pwdata_i[W-1:0];
				end
				if (trig | os_zero) begin
					counter <= reload;
				end else if (wr_timer & ~running) begin
					counter <= pwdata_i[W-1:0];
				end else if (running & tick) begin
					counter <= counter - W'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Run, flags and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			running <= 1'b0;
			ovf_flag <= 1'b0;
			first_seen <= 1'b0;
			edges_seen <= 2'h0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= next_irq;
			if (!is_oneshot || !next_start) begin
				running <= 1'b0;
			end else if (trig) begin
				running <= 1'b1;
			end else if (os_zero) begin
				running <= 1'b0;
			end
			if (meas_ovf) begin
				ovf_flag <= 1'b1;
			end else if (wr_mode & start_flag) begin
				ovf_flag <= 1'b0;
			end
			if (start_rise || !is_meas) begin
				first_seen <= 1'b0;
				edges_seen <= 2'h0;
			end else if (meas_edge) begin
				first_seen <= 1'b1;
				if (edges_seen != `EDGES_VALID) begin
					edges_seen <= edges_seen + 2'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel pin and APB answer
	// ----------------------------------------------------------------
	// The pulse output follows the run state one cycle late; measurement mode keeps the pin an input.
	wire next_pin_out = (pin_fn == oneshot_timer_pkg::pin_pulse) ? running : gpio_out;
	wire next_pin_oe = ~is_meas & ((pin_fn == oneshot_timer_pkg::pin_pulse) |
		((pin_fn == oneshot_timer_pkg::pin_gpio) & gpio_oe));
	// In one-shot mode the timer read shows the live counter; software must treat it as undefined.
	wire [W-1:0] timer_view = is_meas ? reload : counter;
	wire [31:0] next_rdata =
		(paddr_i == AW'(`REG_MODE)) ? {23'h0, mode_reg} :
		(paddr_i == AW'(`REG_CTRL)) ? {28'h0, gpio_oe, gpio_out, 1'b0, start_flag} :
		(paddr_i == AW'(`REG_TIMER)) ? 32'(timer_view) :
		(paddr_i == AW'(`REG_STATUS)) ? {29'h0, edges_seen == `EDGES_VALID, ovf_flag, running} : 32'h0;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			pready_o <= psel_i & penable_i & ~pready_o;
			pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
			prdata_o <= (psel_i & ~pwrite_i) ? next_rdata : 32'h0;
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_zero_reload;
		os_zero && !trig && next_start |=> !running && counter == $past(reload);
	endproperty
	a_zero_reload: assert property (p_zero_reload) else $error("one-shot did not reload and halt");

	property p_retrigger;
		trig |=> running && counter == $past(reload);
	endproperty
	a_retrigger: assert property (p_retrigger) else $error("trigger did not restart count");

	property p_stop_flag;
		ce_i && !next_start |=> !running;
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("clearing start did not stop");

	property p_zero_irq;
		os_zero |=> irq_o;
	endproperty
	a_zero_irq: assert property (p_zero_irq) else $error("no interrupt at zero");

	property p_write_stopped;
		wr_timer && is_oneshot && !running && !trig |=> counter == $past(pwdata_i[W-1:0]) && reload == counter;
	endproperty
	a_write_stopped: assert property (p_write_stopped) else $error("stopped write missed counter");

	property p_write_running;
		wr_timer && is_oneshot && running && !trig && !os_zero |=> reload == $past(pwdata_i[W-1:0]) &&
			counter == $past(counter) - W'($past(tick));
	endproperty
	a_write_running: assert property (p_write_running) else $error("running write touched counter");

	property p_capture;
		meas_edge && !start_rise |=> reload == $past(counter) && counter == '0;
	endproperty
	a_capture: assert property (p_capture) else $error("edge capture wrong");

	property p_meas_hold;
		ce_i && is_meas && !start_flag && !wr_mode && !start_rise |=> $stable(counter);
	endproperty
	a_meas_hold: assert property (p_meas_hold) else $error("measurement counted while stopped");

	property p_first_edge;
		meas_edge && !first_seen && !meas_ovf |=> !irq_o;
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("interrupt on first edge");

	property p_overflow;
		meas_ovf |=> ovf_flag && irq_o;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	property p_ovf_clear;
		wr_mode && start_flag && !meas_ovf |=> !ovf_flag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

	property p_no_meas_write;
		wr_timer && is_meas && !meas_edge |=> $stable(reload);
	endproperty
	a_no_meas_write: assert property (p_no_meas_write) else $error("measurement accepted a write");

endmodule

/* File: test/pulse_source.sv */
// Far-side model of the channel pin: a square-wave source with a settable half period.
// Assumes the design drives the pin only while pin_oe is high.
`timescale 1ns/1ps
module pulse_source (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic [15:0] half_i,
	input wire logic oe_i,
	input wire logic drive_i,
	output logic pin_o
);
	logic level;
	logic [15:0] cnt;
	// The level is held between bursts, as a real source parked on a static level would be.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level <= 1'b0;
			cnt <= 16'h0000;
		end else if (run_i && cnt + 16'h0001 >= half_i) begin
			cnt <= 16'h0000;
			level <= ~level;
		end else begin
			cnt <= run_i ? cnt + 16'h0001 : 16'h0000;
		end
	end
	assign pin_o = oe_i ? drive_i : level;
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the one-shot / pulse measurement timer over APB.
// Assumes the design answers each APB access after one wait state.
`timescale 1ns/1ps
module testbench;
	logic ref_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, ovf = 0, subclk = 0, run = 0;
	logic [3:0] paddr = 4'h0;
	logic [15:0] half = 16'h000a;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pin_out, pin_oe, irq, pin_in, err, prev_pin = 0;
	int errors = 0, tests_run = 0, cyc = 0, irqs = 0, edges = 0, flips = 0, dt, n0;

	oneshot_and_pulse_measure_timer uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pin_in_i(pin_in),
		.ovf_in_i(ovf), .subclk_i(subclk), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .irq_o(irq));
	pulse_source src (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .run_i(run), .half_i(half), .oe_i(pin_oe),
		.drive_i(pin_out), .pin_o(pin_in));

	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		subclk <= ~subclk;
		prev_pin <= pin_in;
		if (irq === 1'b1) irqs <= irqs + 1;
		if (pin_in === 1'b1 && prev_pin === 1'b0) edges <= edges + 1;
		if (pin_in !== prev_pin) flips <= flips + 1;
		if (cyc > 90000) begin
			errors++;
			final_report();
		end
	end

	// ----------------------------------------
	// Bus, compare and wait helpers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1;
		do @(posedge ref_clk_i); while (pready !== 1'b1 && cyc < 90000);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		check(32'((got >= lo) && (got <= hi)), 32'h1);
	endtask
	// Waits for a new interrupt under a bound; dt is the delay in cycles.
	task automatic wait_irq(input int lim);
		int t0;
		t0 = cyc;
		n0 = irqs;
		while (irqs == n0 && cyc - t0 < lim) @(posedge ref_clk_i);
		dt = cyc - t0;
		check(32'(irqs - n0), 32'h1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(0, 4'h0, 0); check(rd, 32'h0);
		apb(0, 4'hc, 0); check(rd, 32'h0);
		apb(0, 4'h2, 0); check(32'(err), 32'h1);
		apb(1, 4'h4, 32'he); apb(0, 4'h4, 0); check(rd, 32'hc);
		check({pin_oe, pin_out}, 2'h3);
		$display("test regs done");
	endtask
	task automatic t_oneshot();
		apb(1, 4'h0, 32'h22); apb(1, 4'h8, 5); apb(1, 4'h4, 3);
		wait_irq(20); check_rng(dt, 5, 8);
		n0 = irqs; repeat (30) @(posedge ref_clk_i);
		check(irqs, n0);
		apb(1, 4'h0, 32'h122); apb(1, 4'h8, 2); apb(1, 4'h4, 3);
		wait_irq(100); check_rng(dt, 35, 66);
		apb(1, 4'h0, 32'h1a2); apb(1, 4'h8, 2); apb(1, 4'h4, 3);
		wait_irq(200); check_rng(dt, 67, 130);
		apb(1, 4'h0, 32'h22);
		apb(1, 4'h8, 12); apb(1, 4'h4, 3); n0 = irqs; apb(1, 4'h8, 3);
		apb(1, 4'h4, 3); check(irqs, n0);
		wait_irq(30); check_rng(dt, 3, 6);
		apb(1, 4'h8, 40); apb(1, 4'h4, 3);
		repeat (2) @(posedge ref_clk_i);
		check({pin_oe, pin_out}, 2'h3);
		apb(1, 4'h4, 0); n0 = irqs;
		repeat (60) @(posedge ref_clk_i);
		check(irqs, n0);
		apb(0, 4'hc, 0); check(rd & 1, 0);
		check({pin_oe, pin_out}, 2'h2);
		$display("test oneshot done");
	endtask
	task automatic t_triggers();
		apb(1, 4'h0, 32'h62); apb(1, 4'h8, 4); apb(1, 4'h4, 1); n0 = irqs;
		repeat (20) @(posedge ref_clk_i);
		check(irqs, n0);
		ovf <= 1; @(posedge ref_clk_i); ovf <= 0;
		wait_irq(20); check_rng(dt, 4, 8);
		apb(1, 4'h0, 32'h1a); half <= 16'h0003; run <= 1;
		repeat (4) @(posedge ref_clk_i); run <= 0;
		wait_irq(20);
		$display("test triggers done");
	endtask
	task automatic t_measure(input logic [31:0] mode, input logic [15:0] h, input logic [31:0] lo, input bit wd);
		int e0, f0;
		apb(1, 4'h4, 0); apb(1, 4'h0, mode); half <= h; run <= 1; e0 = edges;
		f0 = flips;
		apb(1, 4'h4, 1); n0 = irqs;
		repeat (20 * h) @(posedge ref_clk_i);
		run <= 0; repeat (10) @(posedge ref_clk_i);
		check(32'(irqs - n0), 32'((wd ? flips - f0 : edges - e0) - 1));
		apb(0, 4'hc, 0); check(rd & 4, 4);
		apb(0, 4'h8, 0); check_rng(rd, lo, lo + 1);
		apb(1, 4'h8, 32'h1234); apb(0, 4'h8, 0); check_rng(rd, lo, lo + 1);
		$display("test measure done");
	endtask
	task automatic t_overflow();
		apb(1, 4'h4, 0); apb(1, 4'h0, 32'h1b); apb(1, 4'h4, 1);
		wait_irq(66000); check_rng(dt, 65535, 65540);
		apb(0, 4'hc, 0); check(rd & 2, 2);
		apb(1, 4'h0, 32'h1b); apb(0, 4'hc, 0); check(rd & 2, 0);
		$display("test overflow done");
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1;
		t_regs();
		t_oneshot();
		t_triggers();
		t_measure(32'h1b, 16'h000a, 19, 0);
		t_measure(32'h9b, 16'h0020, 7, 0);
		t_measure(32'h1f, 16'h000a, 9, 1);
		t_overflow();
		final_report();
	end
endmodule
